// [chain_adc_dev.sv]
// Purpose: Converter end of the daisy chain: conversion start, result load, shift-through
// Assumes: Link pins are asynchronous to sys_clk_i and are slow versus it
// Notes: Conversion itself is modelled as a fixed timer; the sample arrives on sample_data_i
//
// Overview of operation
// [RL1] Idle with input and start low: output low
// [RL2] Start rise, clock low: chain mode, no busy
// [RL3] Start rise, clock high: chain mode, busy
// [RL4] Host keeps start high through conversion, readback
// [RL5] No busy: MSB out at completion, then power down
// [RL6] No busy: rest shifts out on falling edges
// [RL7] Input shifts into register on falling edges
// [RL8] No busy: host gives sixteen clocks per device
// [RL9] Busy: sixteen clocks per device plus one
// [RL10] Busy: output high once chain has converted
// [RL11] Host may start readback on busy rise
// [RL12] Busy: after signal, power down, shift MSB first
// [RL13] Output stays valid across both clock edges
// [RL14] Host should capture on the falling edge
// [RL15] Conversion rate leaves room for full readback
// [RL16] Busy: acquisition and low power until next start
// [RL17] Host keeps lines quiet around start edge
// [RL18] Host keeps clock quiet during most conversion
// [RL19] Result loads into register at completion
`timescale 1ns/1ps
module chain_adc_dev (
	// System
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Link
	chain_adc_if.dev link,
	// Converter core side
	input wire logic [chain_adc_pkg::DATA_BITS-1:0] sample_data_i,
	output logic sample_o,
	output logic converting_o,
	output logic busy_mode_o,
	output logic power_down_o
);
	import chain_adc_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CONV,
		ST_READ
	} dev_state_t;

	// ------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------
	logic cnv_s1_reg;
	logic cnv_s2_reg;
	logic cnv_d_reg;
	logic sclk_s1_reg;
	logic sclk_s2_reg;
	logic sclk_d_reg;
	logic sdi_s1_reg;
	logic sdi_s2_reg;
	logic cnv_rise;
	logic sclk_fall;

	// Two stages each; only the second stage and its delayed copy feed logic
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			cnv_s1_reg <= 1'b0;
			cnv_s2_reg <= 1'b0;
			cnv_d_reg <= 1'b0;
			sclk_s1_reg <= 1'b0;
			sclk_s2_reg <= 1'b0;
			sclk_d_reg <= 1'b0;
			sdi_s1_reg <= 1'b0;
			sdi_s2_reg <= 1'b0;
		end else begin
			cnv_s1_reg <= link.convert_start;
			cnv_s2_reg <= cnv_s1_reg;
			cnv_d_reg <= cnv_s2_reg;
			sclk_s1_reg <= link.serial_clk;
			sclk_s2_reg <= sclk_s1_reg;
			sclk_d_reg <= sclk_s2_reg;
			sdi_s1_reg <= link.serial_data_in;
			sdi_s2_reg <= sdi_s1_reg;
		end
	end

	assign cnv_rise = cnv_s2_reg & ~cnv_d_reg;
	assign sclk_fall = ~sclk_s2_reg & sclk_d_reg;

	// ------------------------------------------------------------
	// Conversion and shift state
	// ------------------------------------------------------------
	dev_state_t state_reg;
	dev_state_t state_next;
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic busy_en_reg;
	logic busy_en_next;
	logic busy_phase_reg;
	logic busy_phase_next;
	logic [DATA_BITS-1:0] shift_reg;
	logic [DATA_BITS-1:0] shift_next;
	logic sdo_reg;
	logic sdo_next;
	logic sdo_oe_reg;
	logic sdo_oe_next;
	logic sample_reg;
	logic sample_next;
	logic pd_reg;
	logic pd_next;

	localparam logic [7:0] CONV_LAST = 8'(CONV_CYC - 1);

	// Next-state logic; shifted data bits only advance on a seen falling edge
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		busy_en_next = busy_en_reg;
		busy_phase_next = busy_phase_reg;
		shift_next = shift_reg;
		sdo_next = sdo_reg;
		sdo_oe_next = sdo_oe_reg;
		sample_next = 1'b0;
		pd_next = pd_reg;
		unique case (state_reg)
			ST_IDLE: begin
				sdo_next = 1'b0;
				// Drive low only while both input and start are low
				sdo_oe_next = ~sdi_s2_reg & ~cnv_s2_reg; // RL1
				if (cnv_rise) begin
					// Clock level at the start edge picks the busy option
					busy_en_next = sclk_s2_reg; // RL2 RL3
					state_next = ST_CONV;
					cnt_next = 8'h00;
					sample_next = 1'b1;
					pd_next = 1'b0;
					sdo_oe_next = 1'b1;
				end
			end
			ST_CONV: begin
				// Conversion runs to its end whatever the start line does
				sdo_oe_next = 1'b1;
				sdo_next = 1'b0;
				cnt_next = cnt_reg + 8'h01;
				if (cnt_reg == CONV_LAST) begin
					shift_next = sample_data_i; // RL19
					pd_next = 1'b1; // RL16
					busy_phase_next = busy_en_reg;
					state_next = ST_READ;
					if (busy_en_reg) begin
						// Busy bit passes the upstream level, so the line rises
						// only once every device up the chain is done
						sdo_next = sdi_s2_reg; // RL10
					end else begin
						sdo_next = sample_data_i[DATA_BITS-1]; // RL5
					end
				end
			end
			ST_READ: begin
				sdo_oe_next = 1'b1;
				if (busy_phase_reg) begin
					sdo_next = sdi_s2_reg; // RL10
					if (sclk_fall) begin
						// The extra clock retires the busy bit in every device
						// at once, so the chain stays word aligned
						busy_phase_next = 1'b0;
						sdo_next = shift_reg[DATA_BITS-1]; // RL12
					end
				end else if (sclk_fall) begin
					shift_next = {shift_reg[DATA_BITS-2:0], sdi_s2_reg}; // RL7
					sdo_next = shift_reg[DATA_BITS-2]; // RL6 RL12
				end
				// Frame ends when the host drops the start line
				if (~cnv_s2_reg) begin
					state_next = ST_IDLE;
					busy_phase_next = 1'b0;
					sdo_next = 1'b0;
					sdo_oe_next = ~sdi_s2_reg;
				end
			end
			default: begin
				state_next = ST_IDLE;
				sdo_oe_next = 1'b0;
			end
		endcase
	end

	// Register stage for the state group
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 8'h00;
			busy_en_reg <= 1'b0;
			busy_phase_reg <= 1'b0;
			shift_reg <= RESULT_RST;
			sdo_reg <= 1'b0;
			sdo_oe_reg <= 1'b0;
			sample_reg <= 1'b0;
			pd_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			busy_en_reg <= busy_en_next;
			busy_phase_reg <= busy_phase_next;
			shift_reg <= shift_next;
			sdo_reg <= sdo_next;
			sdo_oe_reg <= sdo_oe_next;
			sample_reg <= sample_next;
			pd_reg <= pd_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Line held between falling edges, valid at the host's rising edge too
	assign link.serial_data_out = sdo_reg; // RL13
	assign link.serial_data_out_oe = sdo_oe_reg;
	assign sample_o = sample_reg;
	assign converting_o = (state_reg == ST_CONV);
	assign busy_mode_o = busy_en_reg;
	assign power_down_o = pd_reg;

endmodule : chain_adc_dev

// [chain_adc_host.sv]
// Purpose: Host end of the chain: starts conversions, clocks the chain, collects words
// Assumes: CHAIN_LEN devices wired in series; serial_data_in feeds the far device
// Notes: Words leave through a two-entry buffer; a full buffer stalls the serial clock
`timescale 1ns/1ps
module chain_adc_host (
	// System
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Link
	chain_adc_if.host link,
	// Frame request
	input wire logic start_i,
	input wire logic busy_mode_i,
	output logic start_ready_o,
	// Word stream, nearest device first
	output logic word_valid_o,
	output logic [chain_adc_pkg::DATA_BITS-1:0] word_data_o,
	input wire logic word_ready_i
);
	import chain_adc_pkg::*;

	typedef enum logic [2:0] {
		H_IDLE,
		H_SETUP,
		H_HOLD,
		H_CONV,
		H_LOW,
		H_HIGH,
		H_GAP
	} host_state_t;

	localparam logic [6:0] BITS_PLAIN = 7'(DATA_BITS * CHAIN_LEN);
	localparam logic [6:0] BITS_BUSY = 7'(DATA_BITS * CHAIN_LEN + BUSY_EXTRA);

	// ------------------------------------------------------------
	// Output line synchroniser
	// ------------------------------------------------------------
	logic sdo_s1_reg;
	logic sdo_s2_reg;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			sdo_s1_reg <= 1'b0;
			sdo_s2_reg <= 1'b0;
		end else begin
			sdo_s1_reg <= link.serial_data_out_level;
			sdo_s2_reg <= sdo_s1_reg;
		end
	end

	// ------------------------------------------------------------
	// Two-entry word buffer
	// ------------------------------------------------------------
	logic [DATA_BITS-1:0] mem [0:1];
	logic wp_reg;
	logic rp_reg;
	logic [1:0] fill_reg;
	logic push;
	logic pop;
	logic [DATA_BITS-1:0] push_data;
	logic full;

	assign full = (fill_reg == 2'h2);
	assign pop = word_valid_o & word_ready_i;

	// Storage and pointers; simultaneous push and pop keeps the fill level
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wp_reg <= 1'b0;
			rp_reg <= 1'b0;
			fill_reg <= 2'h0;
			mem[0] <= RESULT_RST;
			mem[1] <= RESULT_RST;
		end else begin
			if (push) begin
				mem[wp_reg] <= push_data;
				wp_reg <= ~wp_reg;
			end
			if (pop) begin
				rp_reg <= ~rp_reg;
			end
			fill_reg <= fill_reg + {1'b0, push} - {1'b0, pop};
		end
	end

	assign word_valid_o = (fill_reg != 2'h0);
	assign word_data_o = mem[rp_reg];

	// ------------------------------------------------------------
	// Frame sequencer
	// ------------------------------------------------------------
	host_state_t st_reg;
	host_state_t st_next;
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic [6:0] bit_reg;
	logic [6:0] bit_next;
	logic [3:0] dbit_reg;
	logic [3:0] dbit_next;
	logic [DATA_BITS-1:0] acc_reg;
	logic [DATA_BITS-1:0] acc_next;
	logic busy_reg;
	logic busy_next;
	logic cnv_reg;
	logic cnv_next;
	logic sclk_reg;
	logic sclk_next;
	logic sdi_reg;
	logic sdi_next;
	logic discard;
	logic word_end;

	// The first clock in busy mode carries the busy bit, not data
	assign discard = busy_reg & (bit_reg == 7'h00);
	assign word_end = ~discard & (dbit_reg == 4'hf);
	assign push_data = {acc_reg[DATA_BITS-2:0], sdo_s2_reg};

	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		bit_next = bit_reg;
		dbit_next = dbit_reg;
		acc_next = acc_reg;
		busy_next = busy_reg;
		cnv_next = cnv_reg;
		sclk_next = sclk_reg;
		sdi_next = sdi_reg;
		push = 1'b0;
		unique case (st_reg)
			H_IDLE: begin
				if (start_i) begin
					busy_next = busy_mode_i;
					// Clock level before the start edge selects the busy option
					sclk_next = busy_mode_i;
					cnt_next = 8'h00;
					st_next = H_SETUP;
				end
			end
			H_SETUP: begin
				cnt_next = cnt_reg + 8'h01;
				// Clock and data held still before the start edge
				if (cnt_reg == 8'(QUIET_PRE_CYC - 1)) begin // RL17
					cnv_next = 1'b1;
					// Far device sees start on its input in busy mode
					sdi_next = busy_reg;
					cnt_next = 8'h00;
					st_next = H_HOLD;
				end
			end
			H_HOLD: begin
				cnt_next = cnt_reg + 8'h01;
				if (cnt_reg == 8'(QUIET_POST_CYC - 1)) begin // RL17
					// Clock parks low early, then stays quiet for the conversion
					sclk_next = 1'b0; // RL18
					cnt_next = 8'h00;
					bit_next = 7'h00;
					dbit_next = 4'h0;
					st_next = H_CONV;
				end
			end
			H_CONV: begin
				cnt_next = cnt_reg + 8'h01;
				if (busy_reg ? sdo_s2_reg : (cnt_reg == 8'(CONV_WAIT_CYC - 1))) begin // RL11
					cnt_next = 8'h00;
					st_next = H_HIGH;
					sclk_next = 1'b1;
				end
			end
			H_HIGH: begin
				cnt_next = cnt_reg + 8'h01;
				// A full buffer holds the clock high before a word's last capture until a word drains
				if (cnt_reg >= 8'(SCLK_HALF_CYC - 1) && !(word_end && full)) begin
					// Capture right at the falling edge
					if (!discard) begin // RL14
						acc_next = push_data;
						dbit_next = dbit_reg + 4'h1;
						push = word_end;
					end
					sclk_next = 1'b0;
					cnt_next = 8'h00;
					bit_next = bit_reg + 7'h01;
					if (bit_reg == (busy_reg ? BITS_BUSY : BITS_PLAIN) - 7'h01) begin // RL8 RL9
						// Start stays high to the end of readback
						cnv_next = 1'b0; // RL4
						sdi_next = 1'b0;
						st_next = H_GAP;
					end else begin
						st_next = H_LOW;
					end
				end
			end
			H_LOW: begin
				cnt_next = cnt_reg + 8'h01;
				if (cnt_reg == 8'(SCLK_HALF_CYC - 1)) begin
					sclk_next = 1'b1;
					cnt_next = 8'h00;
					st_next = H_HIGH;
				end
			end
			H_GAP: begin
				// Next start only after the whole chain is read
				cnt_next = cnt_reg + 8'h01;
				if (cnt_reg == 8'(GAP_CYC - 1)) begin // RL15
					st_next = H_IDLE;
				end
			end
			default: begin
				st_next = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			st_reg <= H_IDLE;
			cnt_reg <= 8'h00;
			bit_reg <= 7'h00;
			dbit_reg <= 4'h0;
			acc_reg <= RESULT_RST;
			busy_reg <= 1'b0;
			cnv_reg <= 1'b0;
			sclk_reg <= 1'b0;
			sdi_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			bit_reg <= bit_next;
			dbit_reg <= dbit_next;
			acc_reg <= acc_next;
			busy_reg <= busy_next;
			cnv_reg <= cnv_next;
			sclk_reg <= sclk_next;
			sdi_reg <= sdi_next;
		end
	end

	assign link.convert_start = cnv_reg;
	assign link.serial_clk = sclk_reg;
	assign link.serial_data_in = sdi_reg;
	assign start_ready_o = (st_reg == H_IDLE);

endmodule : chain_adc_host

// [chain_adc_if.sv]
// Purpose: Four-wire chain link between the host and one converter end
// Assumes: Output line is pulled low when nobody drives it
// Notes: Testbench may join several device ends by wiring lines between instances
`timescale 1ns/1ps
interface chain_adc_if;
	logic convert_start;
	logic serial_clk;
	logic serial_data_in;
	logic serial_data_out;
	logic serial_data_out_oe;
	logic serial_data_out_level;

	// Resolved line level seen by the host; undriven reads as low
	assign serial_data_out_level = serial_data_out_oe & serial_data_out;

	modport dev (
		input convert_start,
		input serial_clk,
		input serial_data_in,
		output serial_data_out,
		output serial_data_out_oe
	);

	modport host (
		output convert_start,
		output serial_clk,
		output serial_data_in,
		input serial_data_out_level
	);
endinterface : chain_adc_if

// [chain_adc_pkg.sv]
// Purpose: Shared constants for the daisy-chained converter link (device and host ends)
// Assumes: 50 MHz system clock on both ends
// Notes: Timing figures live here; cycle counts are derived from them, except GAP_CYC which is given directly
package chain_adc_pkg;

	// ------------------------------------------------------------
	// Word and chain shape
	// ------------------------------------------------------------
	localparam int DATA_BITS = 16;
	localparam int CHAIN_LEN = 2;
	localparam int BUSY_EXTRA = 1;

	// ------------------------------------------------------------
	// Timing figures and derived cycle counts
	// ------------------------------------------------------------
	localparam int CLK_NS = 20;
	// Conversion time of the device model
	localparam int T_CONV_NS = 1600;
	localparam int CONV_CYC = T_CONV_NS / CLK_NS;
	// Longest conversion the host waits for without a busy indicator
	localparam int T_CONV_MAX_NS = 2000;
	localparam int CONV_WAIT_CYC = (T_CONV_MAX_NS + CLK_NS - 1) / CLK_NS;
	// Quiet time on clock and data around the convert-start edge
	localparam int T_QUIET_PRE_NS = 30;
	localparam int QUIET_PRE_CYC = (T_QUIET_PRE_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_QUIET_POST_NS = 10;
	localparam int QUIET_POST_CYC = (T_QUIET_POST_NS + CLK_NS - 1) / CLK_NS;
	// Serial clock made by the host
	localparam int T_SCLK_NS = 160;
	localparam int SCLK_HALF_CYC = T_SCLK_NS / (2 * CLK_NS);
	// Gap after a frame before the next start is accepted
	localparam int GAP_CYC = 4;

	localparam logic [15:0] RESULT_RST = 16'h0000;

endpackage : chain_adc_pkg

// [chain_adc_properties.sv]
// Purpose: Timing properties of the link as seen at the converter end nearest the host
// Assumes: Host paces frames; the near end's input is the far end's resolved line
// Notes: Clock rises are counted per frame so that the frame length can be checked
`timescale 1ns/1ps
module chain_adc_properties (
	// System
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Link of the near end
	input wire logic convert_start,
	input wire logic serial_clk,
	input wire logic serial_data_in,
	input wire logic serial_data_out,
	input wire logic serial_data_out_oe
);
	import chain_adc_pkg::*;

	// ----
	// Frame bookkeeping
	// ----
	logic clk_prev_reg, clk_prev_next;
	logic start_prev_reg, start_prev_next;
	logic mode_reg, mode_next;
	logic [7:0] rise_cnt_reg, rise_cnt_next;

	// Only rises inside a frame count; the busy-mode set-up rise comes before the start
	always_comb begin
		clk_prev_next = serial_clk;
		start_prev_next = convert_start;
		mode_next = (convert_start && !start_prev_reg) ? serial_clk : mode_reg;
		rise_cnt_next = rise_cnt_reg;
		if (!convert_start) begin
			rise_cnt_next = 8'h00;
		end else if (serial_clk && !clk_prev_reg) begin
			rise_cnt_next = rise_cnt_reg + 8'h01;
		end
	end

	// Registers of the bookkeeping
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			clk_prev_reg <= 1'b0;
			start_prev_reg <= 1'b0;
			mode_reg <= 1'b0;
			rise_cnt_reg <= 8'h00;
		end else begin
			clk_prev_reg <= clk_prev_next;
			start_prev_reg <= start_prev_next;
			mode_reg <= mode_next;
			rise_cnt_reg <= rise_cnt_next;
		end
	end

	// ----
	// Properties
	// ----
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	sequence plain_start_s;
		$rose(convert_start) && !serial_clk;
	endsequence
	sequence busy_start_s;
		$rose(convert_start) && serial_clk;
	endsequence
	sequence idle_s;
		(!convert_start && !serial_data_in) [*6];
	endsequence

	idle_low_a: assert property (idle_s |-> serial_data_out_oe && !serial_data_out)
		else $error("idle line not driven low");
	plain_hold_a: assert property (plain_start_s |-> ##90 (serial_data_out_oe && $stable(serial_data_out)) [*8])
		else $error("first bit not held before readback");
	busy_low_a: assert property (busy_start_s |-> ##1 !serial_data_out [*8])
		else $error("busy line not low during conversion");
	busy_done_a: assert property (busy_start_s |-> ##[78:100] (serial_data_out_oe && serial_data_out))
		else $error("busy line did not rise after conversion");
	valid_rise_a: assert property (convert_start && $rose(serial_clk) |-> ##1 $stable(serial_data_out) [*3])
		else $error("data moved around a rising clock");
	clock_count_a: assert property ($fell(convert_start) |->
		int'(rise_cnt_reg) == DATA_BITS * CHAIN_LEN + (mode_reg ? BUSY_EXTRA : 0))
		else $error("wrong clock count in frame");
	end_low_a: assert property ($fell(convert_start) |-> !serial_clk)
		else $error("frame ended with clock high");
	quiet_start_a: assert property ($rose(convert_start) |-> $stable(serial_clk) && $past(serial_clk, 2) == serial_clk)
		else $error("clock moved near the start edge");
endmodule : chain_adc_properties

// [tb_top.sv]
// Purpose: Host joined to a chain of two converter ends, words scored against samples
// Assumes: Near end feeds the host; far end takes the host's data line
// Notes: A queue of expected words is filled by the driver and emptied by the monitor
`timescale 1ns/1ps
module tb_top;
	import chain_adc_pkg::*;

	logic sys_clk_i, rst_i, start_i, busy_mode_i, word_ready_i, hold_ready;
	logic start_ready_o, word_valid_o;
	logic [15:0] word_data_o, n_data, f_data;
	logic n_sample, n_conv, n_busy, n_pd, f_sample, f_conv, f_busy, f_pd;
	logic [15:0] exp_q[$];
	logic [15:0] edge_v [4] = '{16'h8000, 16'h0001, 16'hffff, 16'h0000};
	int n_fail = 0;
	int n_tests = 0;

	chain_adc_if if_h();
	chain_adc_if if_f();
	chain_adc_if if_n();
	// Chain wiring: host lines fan out, far line feeds the near end, near line reaches the host
	assign if_f.convert_start = if_h.convert_start;
	assign if_f.serial_clk = if_h.serial_clk;
	assign if_f.serial_data_in = if_h.serial_data_in;
	assign if_n.convert_start = if_h.convert_start;
	assign if_n.serial_clk = if_h.serial_clk;
	assign if_n.serial_data_in = if_f.serial_data_out_level;
	assign if_h.serial_data_out = if_n.serial_data_out;
	assign if_h.serial_data_out_oe = if_n.serial_data_out_oe;

	chain_adc_host u_chain_adc_host (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(if_h.host),
		.start_i(start_i), .busy_mode_i(busy_mode_i), .start_ready_o(start_ready_o),
		.word_valid_o(word_valid_o), .word_data_o(word_data_o), .word_ready_i(word_ready_i));
	chain_adc_dev u_chain_adc_dev_far (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(if_f.dev),
		.sample_data_i(f_data), .sample_o(f_sample), .converting_o(f_conv), .busy_mode_o(f_busy),
		.power_down_o(f_pd));
	chain_adc_dev u_chain_adc_dev_near (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(if_n.dev),
		.sample_data_i(n_data), .sample_o(n_sample), .converting_o(n_conv), .busy_mode_o(n_busy),
		.power_down_o(n_pd));
	chain_adc_properties u_chain_adc_properties (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.convert_start(if_n.convert_start), .serial_clk(if_n.serial_clk),
		.serial_data_in(if_n.serial_data_in), .serial_data_out(if_n.serial_data_out),
		.serial_data_out_oe(if_n.serial_data_out_oe));

	// ----
	// Clock, receiver stalls, scoreboard
	// ----
	always #10 sys_clk_i = ~sys_clk_i;
	always @(negedge sys_clk_i) word_ready_i <= hold_ready ? 1'b0 : ($urandom_range(3) != 0);

	// Every accepted word is the oldest expectation; an unexpected word is a mismatch
	always @(posedge sys_clk_i) begin
		if (!rst_i && word_valid_o === 1'b1 && word_ready_i === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("word_extra", 16'h0001, 16'h0000);
			end else begin
				check("word_data", word_data_o, exp_q.pop_front());
			end
		end
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim

	// Selects what a bounded wait watches; 3 means idle with every word delivered
	function automatic logic probe(input int k);
		case (k)
			0: return start_ready_o;
			1: return n_sample;
			2: return n_pd;
			default: return logic'(exp_q.size() == 0) & start_ready_o;
		endcase
	endfunction : probe

	task automatic wait_on(input int k, input int lim);
		int i;
		for (i = 0; i < lim && probe(k) !== 1'b1; i++) begin
			@(negedge sys_clk_i);
		end
		if (i >= lim) begin
			$display("mismatch wait_%0d expected 1 seen timeout", k);
			n_fail++;
			end_sim();
		end
	endtask : wait_on

	// One frame: results held until conversion ends, device mode and power state checked
	task automatic frame(input logic mode, input logic [15:0] nv, input logic [15:0] fv);
		// The previous readback of the whole chain takes close to 260 cycles
		wait_on(0, 600);
		n_data = nv;
		f_data = fv;
		start_i = 1'b1;
		busy_mode_i = mode;
		exp_q.push_back(nv);
		exp_q.push_back(fv);
		@(negedge sys_clk_i);
		start_i = 1'b0;
		wait_on(1, 10);
		check("sample_far", {15'h0000, f_sample}, 16'h0001);
		repeat (2) @(negedge sys_clk_i);
		check("converting_near", {15'h0000, n_conv}, 16'h0001);
		check("busy_mode_near", {15'h0000, n_busy}, {15'h0000, mode});
		check("busy_mode_far", {15'h0000, f_busy}, {15'h0000, mode});
		check("power_down_conv", {15'h0000, n_pd}, 16'h0000);
		check("power_down_far_conv", {15'h0000, f_pd}, 16'h0000);
		wait_on(2, 120);
		check("converting_end", {15'h0000, n_conv}, 16'h0000);
		check("converting_far_end", {15'h0000, f_conv}, 16'h0000);
		check("power_down_far", {15'h0000, f_pd}, 16'h0001);
	endtask : frame

	// ----
	// Main sequence
	// ----
	initial begin
		sys_clk_i = 1'b0;
		rst_i = 1'b1;
		start_i = 1'b0;
		busy_mode_i = 1'b0;
		hold_ready = 1'b0;
		n_data = 16'h0000;
		f_data = 16'h0000;
		void'($urandom(2579));
		repeat (3) @(negedge sys_clk_i);
		rst_i = 1'b0;
		// Random results in both modes
		for (int k = 0; k < 4; k++) begin
			frame(k[0], 16'($urandom), 16'($urandom));
		end
		wait_on(3, 3000);
		$display("test random_frames done");
		// Boundary words back to back, modes plain, plain, busy, busy
		for (int k = 0; k < 4; k++) begin
			frame(k[1], edge_v[k], edge_v[3 - k]);
		end
		wait_on(3, 3000);
		$display("test edge_words done");
		// Receiver stalls: buffer fills and the serial clock stops high
		hold_ready = 1'b1;
		frame(1'b0, 16'($urandom), 16'($urandom));
		frame(1'b1, 16'($urandom), 16'($urandom));
		repeat (300) @(negedge sys_clk_i);
		check("stall_valid", {15'h0000, word_valid_o}, 16'h0001);
		check("stall_clock", {15'h0000, if_h.serial_clk}, 16'h0001);
		check("stall_ready", {15'h0000, start_ready_o}, 16'h0000);
		hold_ready = 1'b0;
		wait_on(3, 3000);
		$display("test stall done");
		// Reset in mid readback, then a clean frame
		frame(1'b1, 16'($urandom), 16'($urandom));
		// Let a few clocks of the readback pass before the reset cuts it
		repeat (60) @(negedge sys_clk_i);
		rst_i = 1'b1;
		repeat (3) @(negedge sys_clk_i);
		exp_q.delete();
		rst_i = 1'b0;
		check("rst_ready", {15'h0000, start_ready_o}, 16'h0001);
		check("rst_valid", {15'h0000, word_valid_o}, 16'h0000);
		check("rst_start", {15'h0000, if_h.convert_start}, 16'h0000);
		frame(1'b0, 16'($urandom), 16'($urandom));
		wait_on(3, 3000);
		$display("test mid_reset done");
		end_sim();
	end
endmodule : tb_top
